// ===== sim/sfc_spi_ctrl_tb.sv
// Purpose: self-checking bench of the serial controller with a far-side model
// Assumes: clock 50 MHz, SCK_RATIO 8, DEPTH 16
// Notes:   acks are checked against queued expectations by a monitor
`timescale 1ns/1ns
module sfc_spi_ctrl_tb;
	logic clk = 1'b0, resetn = 1'b0, enable = 1'b0, master_mode = 1'b1;
	logic auto_ss = 1'b0, inhibit = 1'b0, tx_wr_valid = 1'b0, rx_rd_req = 1'b0;
	logic [3:0] slave_select_reg = 4'hf;
	logic [7:0] tx_wr_data = 8'h00;
	logic tx_wr_ack, tx_wr_err, rx_rd_ack, rx_rd_err, busy, ratio_err;
	logic [7:0] rx_rd_data, got, m, q, r;
	logic [4:0] tx_occupancy, rx_occupancy;
	logic e_empty, e_half, e_under, e_full, e_ovf, got_t;
	logic sck_out, sck_oe, z_out, z_oe, o_out, o_oe, ss_oe, p_sck, p_mosi, p_ss_n, p_miso;
	logic [3:0] ss_out_n, ex;
	logic sck_w, mosi_w, miso_w, sel_w;
	logic exp_wr[$];
	logic [8:0] exp_rd[$];
	logic [7:0] exp_mosi[$];
	int mismatches = 0, num_checks = 0, k = 0;
	int n_empty = 0, n_half = 0, n_under = 0, n_full = 0;
	always #10 clk = ~clk;
	// each shared pin resolved from the controller's output enables only
	assign sck_w = sck_oe ? sck_out : p_sck;
	assign mosi_w = z_oe ? z_out : p_mosi;
	assign miso_w = o_oe ? o_out : p_miso;
	assign sel_w = ss_oe ? ss_out_n[0] : 1'b1;
	sfc_spi_ctrl #(.SCK_RATIO(8), .DEPTH(16), .NSS(4)) i_sfc_spi_ctrl (
		.clk(clk), .resetn(resetn), .enable(enable), .master_mode(master_mode),
		.auto_ss(auto_ss), .inhibit(inhibit), .slave_select_reg(slave_select_reg),
		.tx_wr_valid(tx_wr_valid), .tx_wr_data(tx_wr_data), .tx_wr_ack(tx_wr_ack),
		.tx_wr_err(tx_wr_err), .rx_rd_req(rx_rd_req), .rx_rd_data(rx_rd_data),
		.rx_rd_ack(rx_rd_ack), .rx_rd_err(rx_rd_err), .tx_occupancy(tx_occupancy),
		.rx_occupancy(rx_occupancy), .busy(busy), .ratio_err(ratio_err),
		.evt_tx_empty(e_empty), .evt_tx_half(e_half), .evt_tx_underrun(e_under),
		.evt_rx_full(e_full), .evt_rx_overflow(e_ovf), .sck_in(sck_w),
		.sck_out(sck_out), .sck_oe(sck_oe), .serial_line_zero_in(mosi_w),
		.serial_line_zero_out(z_out), .serial_line_zero_oe(z_oe),
		.serial_line_one_in(miso_w), .serial_line_one_out(o_out),
		.serial_line_one_oe(o_oe), .slave_select_input_n(p_ss_n),
		.ss_out_n(ss_out_n), .ss_oe(ss_oe));
	sfc_spi_partner i_sfc_spi_partner (.clk(clk), .sck(sck_w), .mosi(mosi_w),
		.miso_in(miso_w), .sel_n(sel_w), .sck_drv(p_sck), .mosi_drv(p_mosi),
		.ss_drv_n(p_ss_n), .miso(p_miso), .got(got), .got_t(got_t));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// single one-cycle requests only
	task automatic wr(input logic [7:0] d, input logic err);
		exp_wr.push_back(err);
		@(posedge clk);
		#2 tx_wr_valid = 1'b1;
		tx_wr_data = d;
		@(posedge clk);
		#2 tx_wr_valid = 1'b0;
	endtask
	task automatic rd(input logic err, input logic [7:0] d);
		exp_rd.push_back({err, d});
		@(posedge clk);
		#2 rx_rd_req = 1'b1;
		@(posedge clk);
		#2 rx_rd_req = 1'b0;
	endtask
	task automatic wait_tx(input logic [4:0] v, input int lim);
		int n;
		n = 0;
		while (tx_occupancy !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk("tx_occ_wait", {11'h0, tx_occupancy}, {11'h0, v});
	endtask
	task automatic wr_rand(input logic err);
		m = $urandom;
		if (!err) exp_mosi.push_back(m);
		wr(m, err);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	always @(posedge clk) begin
		if (tx_wr_ack === 1'b1) chk("wr_err", {15'h0, tx_wr_err}, {15'h0, exp_wr.pop_front()});
		if (rx_rd_ack === 1'b1) chk("rd", {7'h0, rx_rd_err, rx_rd_data}, {7'h0, exp_rd.pop_front()});
		n_empty += int'(e_empty === 1'b1);
		n_half += int'(e_half === 1'b1);
		n_under += int'(e_under === 1'b1);
		n_full += int'(e_full === 1'b1);
	end
	always @(got_t) if ($time > 0) chk("mosi_byte", {8'h0, got}, {8'h0, exp_mosi.pop_front()});
	initial begin
		#300_000; // about eight times the expected run
		mismatches++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h40f99d25));
		tick(3);
		resetn = 1'b1;
		tick(2);
		chk("reset", {tx_occupancy, rx_occupancy, ss_out_n, busy, 1'b0}, 16'h003c);
		enable = 1'b1;
		for (int i = 0; i < 5; i++) begin
			slave_select_reg = (i < 4) ? ~(4'h1 << i) : 4'($urandom);
			ex = 4'hf;
			for (int b = 3; b >= 0; b--) if (!slave_select_reg[b]) ex = ~(4'h1 << b);
			tick(3);
			chk("ss_manual", {12'h0, ss_out_n}, {12'h0, ex});
		end
		slave_select_reg = 4'he;
		enable = 1'b0;
		auto_ss = 1'b1;
		rd(1'b1, 8'h00);
		for (int i = 0; i < 3; i++) wr_rand(1'b0);
		tick(2);
		chk("tx_occ_pre", {11'h0, tx_occupancy}, 16'h3);
		enable = 1'b1;
		wait_tx(5'h0, 3 * 80);
		tick(4);
		chk("rx_occ", {11'h0, rx_occupancy}, 16'h3);
		chk("n_empty", 16'(n_empty), 16'h1);
		for (int i = 0; i < 3; i++) rd(1'b0, 8'h5a + 8'(k++));
		enable = 1'b0;
		for (int i = 0; i < 16; i++) wr_rand(1'b0);
		wr(8'h33, 1'b1);
		tick(2);
		chk("tx_full", {11'h0, tx_occupancy}, 16'h10);
		enable = 1'b1;
		tick(20);
		chk("busy", {15'h0, busy}, 16'h1);
		inhibit = 1'b1;
		tick(10);
		chk("abort", {10'h0, busy, tx_occupancy}, 16'h10);
		inhibit = 1'b0;
		wait_tx(5'h0, 16 * 80);
		tick(4);
		chk("rx_full", {11'h0, rx_occupancy}, 16'h10);
		chk("n_full", 16'(n_full), 16'h1);
		for (int i = 0; i < 2; i++) wr_rand(1'b0);
		tick(100);
		chk("stall", {11'h0, tx_occupancy}, 16'h2);
		for (int i = 0; i < 16; i++) rd(1'b0, 8'h5a + 8'(k++));
		wait_tx(5'h0, 2 * 80);
		tick(4);
		for (int i = 0; i < 2; i++) rd(1'b0, 8'h5a + 8'(k++));
		chk("events", 16'({n_empty[3:0], n_half[3:0]}), 16'h31);
		enable = 1'b0;
		master_mode = 1'b0;
		inhibit = 1'b1;
		tick(2);
		enable = 1'b1;
		r = $urandom;
		wr(r, 1'b0);
		tick(4);
		chk("slave_pins", {13'h0, sck_oe, ss_oe, ratio_err}, 16'h0);
		m = $urandom;
		i_sfc_spi_partner.xfer(m, q);
		chk("slave_out", {8'h0, q}, {8'h0, r});
		tick(6);
		rd(1'b0, m);
		m = $urandom;
		i_sfc_spi_partner.xfer(m, q);
		chk("underrun", {8'h0, q}, 16'h0);
		tick(6);
		chk("n_under", 16'(n_under), 16'h1);
		rd(1'b0, m);
		tick(4);
		chk("pending", 16'(exp_rd.size() + exp_wr.size() + exp_mosi.size()), 16'h0);
		report_and_stop();
	end
endmodule // sfc_spi_ctrl_tb

// ===== sim/sfc_spi_partner.sv
// Purpose: far-side serial device, slave for master tests, master for slave tests
// Assumes: mode 0, msb first, one select line watched
// Notes:   reply of the n-th whole character is REPLY_BASE + n
`timescale 1ns/1ns
module sfc_spi_partner #(
	parameter logic [7:0] REPLY_BASE = 8'h5a
)(
	input  wire logic       clk,
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       miso_in,
	input  wire logic       sel_n,
	output logic            sck_drv,
	output logic            mosi_drv,
	output logic            ss_drv_n,
	output logic            miso,
	output logic [7:0]      got,
	output logic            got_t
);
	logic [7:0] sh_in;
	logic [7:0] sh_out;
	int         nbit;
	int         nchar;
	logic       idle_pat;
	initial begin
		sck_drv = 1'b0;
		mosi_drv = 1'b0;
		ss_drv_n = 1'b1;
		got = 8'h00;
		got_t = 1'b0;
		sh_in = 8'h00;
		sh_out = 8'h00;
		nbit = 0;
		nchar = 0;
		idle_pat = 1'b0;
	end
	always @(posedge clk) idle_pat <= ~idle_pat;
	always @(negedge sel_n) begin
		sh_out = REPLY_BASE + nchar[7:0];
		nbit = 0;
	end
	// a character cut short by select rising is dropped
	always @(posedge sel_n) nbit = 0;
	always @(posedge sck) if (!sel_n) begin
		sh_in = {sh_in[6:0], mosi};
		nbit++;
		if (nbit == 8) begin
			got = sh_in;
			got_t = ~got_t;
			nchar++;
			nbit = 0;
		end
	end
	always @(negedge sck) if (!sel_n) sh_out = {sh_out[6:0], 1'b0};
	// released line shows a changing pattern, never the last bit
	assign miso = sel_n ? idle_pat : sh_out[7];
	// master role: 160 ns clock, edges a fixed offset after our clock edge
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		ss_drv_n = 1'b0;
		#400;
		for (int i = 7; i >= 0; i--) begin
			mosi_drv = d[i];
			#80 sck_drv = 1'b1;
			#80 q = {q[6:0], miso_in};
			sck_drv = 1'b0;
		end
		#400 ss_drv_n = 1'b1;
		mosi_drv = ~mosi_drv;
	endtask
endmodule // sfc_spi_partner

// ===== src/sfc_fifo.sv
// Purpose: show-ahead fifo with valid and ready on both sides
// Assumes: D is a power of two
// Notes:   storage is flip-flops
`timescale 1ns/1ns
module sfc_fifo #(
	parameter int W = 8,
	parameter int D = 16
)(
	input wire logic clk,
	input wire logic resetn,
	sfc_fifo_if.fifo f
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          wr;
	logic          rd;

	assign wr        = f.w_valid & f.w_ready;
	assign rd        = f.r_valid & f.r_ready;
	assign f.w_ready = cnt_r != (AW+1)'(D);
	assign f.r_valid = cnt_r != '0;
	assign f.r_data  = mem_r[rp_r];
	assign f.count   = cnt_r;

	always_ff @(posedge clk) begin
		if (wr) begin
			mem_r[wp_r] <= f.w_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (wr) begin
				wp_r <= wp_r + 1'b1;
			end
			if (rd) begin
				rp_r <= rp_r + 1'b1;
			end
			if (wr && !rd) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (rd && !wr) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	a_fifo_bound: assert property (@(posedge clk) disable iff (!resetn)
		cnt_r <= (AW+1)'(D)) else $error("fifo count above depth");
	a_fifo_step: assert property (@(posedge clk) disable iff (!resetn)
		wr && !rd |=> cnt_r == $past(cnt_r) + 1'b1) else $error("fifo count missed a write");
endmodule // sfc_fifo

// ===== src/sfc_fifo_if.sv
// Purpose: carrier between the controller and its fifos
// Assumes: one writer and one reader
// Notes:   count is the live occupancy
`timescale 1ns/1ns
interface sfc_fifo_if #(
	parameter int W = 8,
	parameter int D = 16
);
	logic                 w_valid;
	logic                 w_ready;
	logic [W-1:0]         w_data;
	logic                 r_valid;
	logic                 r_ready;
	logic [W-1:0]         r_data;
	logic [$clog2(D):0]   count;
	modport fifo (input w_valid, input w_data, input r_ready,
		output w_ready, output r_valid, output r_data, output count);
	modport user (output w_valid, output w_data, output r_ready,
		input w_ready, input r_valid, input r_data, input count);
endinterface

// ===== src/sfc_map.svh
// Purpose: named constants of the serial controller
// Assumes: included by bare name
// Notes:   definitions only
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
`define SFC_CHAR_W    8
`define SFC_LAST_BIT  3'h7
`define SFC_RATIO_DEF 4
`define SFC_DEPTH_DEF 16
`define SFC_NSS_DEF   4
`define SFC_PIN_N     4
`define SFC_PIN_MOSI  0
`define SFC_PIN_MISO  1
`define SFC_PIN_SCK   2
`define SFC_PIN_SS    3
`define SFC_PIN_RST   4'hb
`endif

// ===== src/sfc_pkg.sv
// Purpose: shared types of the serial controller
// Assumes: nothing
// Notes:   state codes are gray along idle, shift, done
package sfc_pkg;
	typedef enum logic [1:0] {
		SFC_IDLE  = 2'b00,
		SFC_SHIFT = 2'b01,
		SFC_DONE  = 2'b11
	} sfc_state_t;
endpackage

// ===== src/sfc_spi_ctrl.sv
// Purpose: standard serial master/slave controller with paired fifos
// Assumes: mode 0 framing, msb first, pins sampled through three flops
// Notes:   control and status bits are plain ports
`timescale 1ns/1ns
`include "sfc_map.svh"
module sfc_spi_ctrl
	import sfc_pkg::*;
#(
	parameter int SCK_RATIO = `SFC_RATIO_DEF,
	parameter int DEPTH     = `SFC_DEPTH_DEF,
	parameter int NSS       = `SFC_NSS_DEF
)(
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire logic                      enable,
	input  wire logic                      master_mode,
	input  wire logic                      auto_ss,
	input  wire logic                      inhibit,
	input  wire logic [NSS-1:0]            slave_select_reg,
	input  wire logic                      tx_wr_valid,
	input  wire logic [`SFC_CHAR_W-1:0]    tx_wr_data,
	output logic                           tx_wr_ack,
	output logic                           tx_wr_err,
	input  wire logic                      rx_rd_req,
	output logic [`SFC_CHAR_W-1:0]         rx_rd_data,
	output logic                           rx_rd_ack,
	output logic                           rx_rd_err,
	output logic [$clog2(DEPTH):0]         tx_occupancy,
	output logic [$clog2(DEPTH):0]         rx_occupancy,
	output logic                           busy,
	output logic                           ratio_err,
	output logic                           evt_tx_empty,
	output logic                           evt_tx_half,
	output logic                           evt_tx_underrun,
	output logic                           evt_rx_full,
	output logic                           evt_rx_overflow,
	input  wire logic                      sck_in,
	output logic                           sck_out,
	output logic                           sck_oe,
	input  wire logic                      serial_line_zero_in,
	output logic                           serial_line_zero_out,
	output logic                           serial_line_zero_oe,
	input  wire logic                      serial_line_one_in,
	output logic                           serial_line_one_out,
	output logic                           serial_line_one_oe,
	input  wire logic                      slave_select_input_n,
	output logic [NSS-1:0]                 ss_out_n,
	output logic                           ss_oe
);
	localparam int HALF = SCK_RATIO / 2;
	localparam int DW   = $clog2(SCK_RATIO) + 1;
	localparam int CW   = $clog2(DEPTH) + 1;

	sfc_fifo_if #(.W(`SFC_CHAR_W), .D(DEPTH)) tx_f ();
	sfc_fifo_if #(.W(`SFC_CHAR_W), .D(DEPTH)) rx_f ();

	sfc_state_t                 st_r;
	logic [`SFC_PIN_N-1:0]      pin_raw;
	logic [`SFC_PIN_N-1:0]      s1_r;
	logic [`SFC_PIN_N-1:0]      s2_r;
	logic [`SFC_PIN_N-1:0]      s3_r;
	logic [`SFC_PIN_N-1:0]      flt_r;
	logic                       sck_p_r;
	logic [`SFC_CHAR_W-1:0]     sh_r;
	logic [2:0]                 bits_r;
	logic                       smp_r;
	logic                       from_fifo_r;
	logic [DW-1:0]              div_r;
	logic                       sck_r;
	logic                       ratio_err_r;
	logic                       sel;
	logic                       slv_en;
	logic                       tick;
	logic                       m_start;
	logic                       load;
	logic                       abort;
	logic                       samp_ev;
	logic                       shift_ev;
	logic                       done;

	// lowest active request wins so at most one select is low
	function automatic logic [NSS-1:0] sfc_onehot_low(input logic [NSS-1:0] v);
		logic [NSS-1:0] r;
		logic           found;
		r     = '1;
		found = 1'b0;
		for (int i = 0; i < NSS; i++) begin
			if (!v[i] && !found) begin
				r[i]  = 1'b0;
				found = 1'b1;
			end
		end
		return r;
	endfunction

	sfc_fifo #(.W(`SFC_CHAR_W), .D(DEPTH)) u_tx_fifo (
		.clk    (clk),
		.resetn (resetn),
		.f      (tx_f)
	);

	sfc_fifo #(.W(`SFC_CHAR_W), .D(DEPTH)) u_rx_fifo (
		.clk    (clk),
		.resetn (resetn),
		.f      (rx_f)
	);

	// pin inputs: three flops, a change counts once stages two and three agree
	assign pin_raw = {slave_select_input_n, sck_in, serial_line_one_in,
		serial_line_zero_in};

	genvar g;
	generate
		for (g = 0; g < `SFC_PIN_N; g++) begin : g_sync
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					s1_r[g]  <= 1'(`SFC_PIN_RST >> g);
					s2_r[g]  <= 1'(`SFC_PIN_RST >> g);
					s3_r[g]  <= 1'(`SFC_PIN_RST >> g);
					flt_r[g] <= 1'(`SFC_PIN_RST >> g);
				end else begin
					s1_r[g] <= pin_raw[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g]) begin
						flt_r[g] <= s3_r[g];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sck_p_r <= 1'b0;
		end else begin
			sck_p_r <= flt_r[`SFC_PIN_SCK];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ratio_err_r <= 1'b0;
		end else begin
			ratio_err_r <= !master_mode && (SCK_RATIO == 2);
		end
	end

	assign sel     = !flt_r[`SFC_PIN_SS];
	assign slv_en  = enable && !master_mode && !ratio_err_r;
	assign tick    = div_r == DW'(HALF - 1);
	// start needs data to send and room for the answer, so master trains never overflow
	assign m_start = enable && !inhibit && tx_f.r_valid && rx_f.w_ready;
	assign load    = master_mode ? m_start : (sel && slv_en);
	assign abort   = master_mode ? (inhibit || !enable) : (!sel || !slv_en);
	assign samp_ev = !master_mode && sel && flt_r[`SFC_PIN_SCK] && !sck_p_r;
	assign shift_ev = master_mode ? (tick && sck_r)
		: (sel && !flt_r[`SFC_PIN_SCK] && sck_p_r);
	assign done    = st_r == SFC_DONE;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= SFC_IDLE;
		end else begin
			case (st_r)
				SFC_IDLE: begin
					if (load) begin
						st_r <= SFC_SHIFT;
					end
				end
				SFC_SHIFT: begin
					if (abort) begin
						st_r <= SFC_IDLE;
					end else if (shift_ev && bits_r == `SFC_LAST_BIT) begin
						st_r <= SFC_DONE;
					end
				end
				SFC_DONE: begin
					st_r <= SFC_IDLE;
				end
				default: begin
					st_r <= SFC_IDLE;
				end
			endcase
		end
	end

	// master clock divider, runs only while shifting
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_r <= '0;
			sck_r <= 1'b0;
		end else if (st_r != SFC_SHIFT || !master_mode) begin
			div_r <= '0;
			sck_r <= 1'b0;
		end else if (tick) begin
			div_r <= '0;
			sck_r <= !sck_r;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			smp_r <= 1'b0;
		end else if (samp_ev) begin
			smp_r <= flt_r[`SFC_PIN_MOSI];
		end
	end

	// master takes its input bit at the falling edge: the filtered pin lags
	// four cycles, and the far end changed it a whole period earlier
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sh_r        <= '0;
			bits_r      <= '0;
			from_fifo_r <= 1'b0;
		end else if (st_r == SFC_IDLE && load) begin
			sh_r        <= tx_f.r_valid ? tx_f.r_data : '0;
			bits_r      <= '0;
			from_fifo_r <= tx_f.r_valid;
		end else if (st_r == SFC_SHIFT && shift_ev) begin
			sh_r   <= {sh_r[`SFC_CHAR_W-2:0],
				master_mode ? flt_r[`SFC_PIN_MISO] : smp_r};
			bits_r <= bits_r + 1'b1;
		end
	end

	// transmit entry leaves only on completion, so an abort keeps it for retry
	assign tx_f.w_valid = tx_wr_valid;
	assign tx_f.w_data  = tx_wr_data;
	assign tx_f.r_ready = done && from_fifo_r;
	assign rx_f.w_valid = done;
	assign rx_f.w_data  = sh_r;
	assign rx_f.r_ready = rx_rd_req;
	assign tx_occupancy = tx_f.count;
	assign rx_occupancy = rx_f.count;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_wr_ack <= 1'b0;
			tx_wr_err <= 1'b0;
		end else begin
			tx_wr_ack <= tx_wr_valid;
			tx_wr_err <= tx_wr_valid && !tx_f.w_ready;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_rd_ack  <= 1'b0;
			rx_rd_err  <= 1'b0;
			rx_rd_data <= '0;
		end else begin
			rx_rd_ack <= rx_rd_req;
			rx_rd_err <= rx_rd_req && !rx_f.r_valid;
			if (rx_rd_req && rx_f.r_valid) begin
				rx_rd_data <= rx_f.r_data;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			evt_tx_empty    <= 1'b0;
			evt_tx_half     <= 1'b0;
			evt_tx_underrun <= 1'b0;
			evt_rx_full     <= 1'b0;
			evt_rx_overflow <= 1'b0;
		end else begin
			evt_tx_empty    <= tx_f.r_ready && tx_f.count == CW'(1);
			evt_tx_half     <= tx_f.r_ready && tx_f.count == CW'(DEPTH / 2 + 1);
			evt_tx_underrun <= st_r == SFC_SHIFT && samp_ev && bits_r == '0
				&& !from_fifo_r;
			evt_rx_full     <= done && rx_f.count == CW'(DEPTH - 1);
			evt_rx_overflow <= done && !rx_f.w_ready;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy      <= 1'b0;
			ratio_err <= 1'b0;
		end else begin
			busy      <= st_r != SFC_IDLE;
			ratio_err <= ratio_err_r;
		end
	end

	// pins: drive only in our role so the shared lines never collide
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sck_out              <= 1'b0;
			sck_oe               <= 1'b0;
			serial_line_zero_out <= 1'b0;
			serial_line_zero_oe  <= 1'b0;
			serial_line_one_out  <= 1'b0;
			serial_line_one_oe   <= 1'b0;
		end else begin
			sck_out              <= sck_r;
			sck_oe               <= enable && master_mode;
			serial_line_zero_out <= sh_r[`SFC_CHAR_W-1];
			serial_line_zero_oe  <= enable && master_mode;
			serial_line_one_out  <= sh_r[`SFC_CHAR_W-1];
			serial_line_one_oe   <= slv_en && sel;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ss_out_n <= '1;
			ss_oe    <= 1'b0;
		end else begin
			ss_oe <= enable && master_mode;
			if (enable && master_mode && (!auto_ss || st_r != SFC_IDLE)) begin
				ss_out_n <= sfc_onehot_low(slave_select_reg);
			end else begin
				ss_out_n <= '1;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_ss_onehot: assert property ($onehot(~ss_out_n) || ss_out_n == '1)
		else $error("select vector not one-hot");
	a_ss_manual: assert property (enable && master_mode && !auto_ss
		|=> ss_out_n == sfc_onehot_low($past(slave_select_reg)))
		else $error("manual select does not follow register");
	a_ss_auto: assert property (enable && master_mode && auto_ss && st_r == SFC_IDLE
		|=> ss_out_n == '1) else $error("auto select held between characters");
	a_inhibit_abort: assert property (master_mode && inhibit && st_r == SFC_SHIFT
		|=> st_r == SFC_IDLE && $stable(tx_occupancy)) else $error("inhibit did not abort");
	a_slave_ratio: assert property (!master_mode && ratio_err_r && st_r == SFC_IDLE
		|=> st_r == SFC_IDLE) else $error("slave ran at rejected ratio");
	a_tx_pop_done: assert property (tx_f.r_ready |-> done && from_fifo_r)
		else $error("transmit count fell without a completed transfer");
	a_full_err: assert property (tx_wr_valid && !tx_f.w_ready
		|=> tx_wr_ack && tx_wr_err) else $error("full write not acked with error");
	a_empty_err: assert property (rx_rd_req && !rx_f.r_valid
		|=> rx_rd_ack && rx_rd_err) else $error("empty read not acked with error");
	a_rx_overflow: assert property (done && !rx_f.w_ready
		|=> evt_rx_overflow && $stable(rx_occupancy)) else $error("overflow not flagged");
	a_master_start: assert property (st_r == SFC_IDLE && master_mode && m_start
		|=> st_r == SFC_SHIFT ##[1:300] sck_out) else $error("master did not start");
	a_char_len: assert property (st_r == SFC_IDLE ##1 st_r == SFC_SHIFT && master_mode
		&& !inhibit && enable [*2] |-> ##[1:1000] (done || abort))
		else $error("character never completed");

	c_master_char: cover property (master_mode && done);
	c_slave_char: cover property (!master_mode && done);
	c_abort: cover property (master_mode && inhibit && st_r == SFC_SHIFT);
	c_overflow: cover property (evt_rx_overflow);
endmodule // sfc_spi_ctrl
